//--- rtl/bus_pkg.sv
// Shared types, constants and helper functions for the parallel bus initiator.
package bus_pkg;

  localparam int ID_W = 3;
  localparam int BYTE_W = 8;
  localparam int LANES = 3;
  localparam int WIDE_W = LANES * BYTE_W;
  localparam int FIFO_DEPTH_DEF = 16;
  localparam int TIMER_W = 16;

  // Bus lines in logical sense: one means asserted, whatever the electrical level.
  typedef struct packed {
    logic bsy;
    logic sel;
    logic cd;
    logic io;
    logic msg;
    logic req;
    logic ack;
    logic atn;
    logic rst;
    logic reqb;
    logic ackb;
    logic dbp;
    logic [BYTE_W-1:0] db;
    logic [LANES-1:0] dbpw;
    logic [WIDE_W-1:0] dbw;
  } bus_pins_t;

  // A byte received from the target together with the phase it arrived in.
  typedef struct packed {
    logic [BYTE_W-1:0] data;
    logic cd;
    logic io;
    logic msg;
    logic perr;
  } rx_byte_t;

  // A word received on the wide lanes with its parity verdict.
  typedef struct packed {
    logic [WIDE_W-1:0] data;
    logic perr;
  } wide_word_t;

  // Clock rate and the bus delays this controller waits out.
  localparam int CLK_MHZ = 10;
  localparam int ARB_WAIT_NS = 3000;
  localparam int SEL_SETTLE_NS = 500;
  localparam int SEL_TIMEOUT_NS = 250000;
  localparam int DATA_SETUP_NS = 200;

  // Least times round up to whole cycles and never fall below one.
  function automatic int cycles_up(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [TIMER_W-1:0] ARB_CYC = TIMER_W'(cycles_up(ARB_WAIT_NS));
  localparam logic [TIMER_W-1:0] SETTLE_CYC = TIMER_W'(cycles_up(SEL_SETTLE_NS));
  localparam logic [TIMER_W-1:0] TIMEOUT_CYC = TIMER_W'(cycles_up(SEL_TIMEOUT_NS));
  localparam logic [TIMER_W-1:0] SETUP_CYC = TIMER_W'(cycles_up(DATA_SETUP_NS));
  localparam logic [TIMER_W-1:0] TIMER_ZERO = '0;
  localparam logic [TIMER_W-1:0] TIMER_ONE = TIMER_W'(1);

  // Odd parity: the parity bit makes the count of ones odd.
  function automatic logic odd_par(input logic [BYTE_W-1:0] b);
    return ~^b;
  endfunction

  // One odd parity bit per wide lane, lowest lane first.
  function automatic logic [LANES-1:0] lane_par(input logic [WIDE_W-1:0] w);
    logic [LANES-1:0] p;
    p = '0;
    for (int i = 0; i < LANES; i++) begin
      p[i] = odd_par(w[i*BYTE_W +: BYTE_W]);
    end
    return p;
  endfunction

  // The data line that stands for a bus ID.
  function automatic logic [BYTE_W-1:0] id_bit(input logic [ID_W-1:0] id);
    return BYTE_W'(1) << id;
  endfunction

  // True when any ID above ours is on the data lines, so we lose arbitration.
  function automatic logic outranked(input logic [BYTE_W-1:0] db, input logic [ID_W-1:0] own);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < BYTE_W; i++) begin
      if (i > int'(own) && db[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

endpackage

//--- rtl/pin_sync.sv
// Three-stage input synchroniser that accepts a change once the last two stages agree.
module pin_sync import bus_pkg::*; #(
  parameter int W = 1
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_sync;

  // Per bit, the filtered value follows only when stages two and three agree.
  always_comb begin
    for (int i = 0; i < W; i++) begin
      next_sync[i] = (s2[i] == s3[i]) ? s3[i] : o_sync[i];
    end
  end

  // The first stage feeds only the second, which keeps metastability contained.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      o_sync <= '0;
    end else begin
      s1 <= i_async;
      s2 <= s1;
      s3 <= s2;
      o_sync <= next_sync;
    end
  end

endmodule

//--- rtl/byte_fifo.sv
// Synchronous FIFO with valid and ready on both sides and a registered write ready.
module byte_fifo import bus_pkg::*; #(
  parameter int WIDTH = BYTE_W,
  parameter int DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_wr_valid,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_wr_ready,
  output logic o_rd_valid,
  output logic [WIDTH-1:0] o_rd_data,
  input wire logic i_rd_ready
);

  localparam int AW = $clog2(DEPTH);

  // Pointers wrap naturally, so the depth must be a power of two.
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_cfg
    $error("byte_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic [AW-1:0] next_wptr;
  logic [AW-1:0] next_rptr;
  logic [AW:0] next_count;
  logic next_wr_ready;
  logic do_wr;
  logic do_rd;

  assign o_rd_valid = (count != '0);
  assign o_rd_data = mem[rptr];

  // Pointer and fill arithmetic; a full FIFO refuses writes through o_wr_ready.
  always_comb begin
    do_wr = i_wr_valid && o_wr_ready;
    do_rd = i_rd_ready && o_rd_valid;
    next_wptr = do_wr ? wptr + AW'(1) : wptr;
    next_rptr = do_rd ? rptr + AW'(1) : rptr;
    next_count = count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    next_wr_ready = (next_count != (AW+1)'(DEPTH));
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      o_wr_ready <= 1'b1;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      count <= next_count;
      o_wr_ready <= next_wr_ready;
    end
  end

  // Storage has no reset; only written entries are ever read.
  always_ff @(posedge i_core_clk) begin
    if (do_wr) begin
      mem[wptr] <= i_wr_data;
    end
  end

endmodule

//--- rtl/bus_initiator.sv
// Initiator end of the parallel peripheral bus: arbitration, selection and byte handshakes.
module bus_initiator import bus_pkg::*; #(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [ID_W-1:0] i_own_id,
  input wire logic [ID_W-1:0] i_target_id,
  input wire logic i_start,
  input wire logic i_atn_req,
  input wire logic i_bus_reset_req,
  input wire logic i_tx_valid,
  input wire logic [BYTE_W-1:0] i_tx_data,
  output logic o_tx_ready,
  output logic o_rx_valid,
  output rx_byte_t o_rx,
  input wire logic i_rx_ready,
  input wire logic i_wide_tx_valid,
  input wire logic [WIDE_W-1:0] i_wide_tx_data,
  output logic o_wide_tx_ready,
  output logic o_wide_rx_valid,
  output wide_word_t o_wide_rx,
  input wire logic i_wide_rx_ready,
  output logic o_connected,
  output logic o_arb_lost,
  output logic o_sel_timeout,
  input wire bus_pins_t i_bus,
  output bus_pins_t o_bus_out,
  output bus_pins_t o_bus_oe
);

  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("bus_initiator needs a FIFO depth of at least 2");
  end

  typedef enum logic [3:0] {ST_IDLE, ST_ARB, ST_SEL, ST_SEL_REL, ST_SEL_WAIT, ST_RESEL,
                            ST_CONN, ST_SETUP, ST_ACK} state_t;
  typedef enum logic [1:0] {W_IDLE, W_SETUP, W_ACK} wstate_t;

  bus_pins_t b;
  logic [$bits(bus_pins_t)-1:0] b_vec;
  logic fifo_rd_valid;
  logic [BYTE_W-1:0] fifo_rd_data;
  logic fifo_rd_ready;
  logic fifo_wr_ready;

  state_t state, next_state;
  logic [TIMER_W-1:0] timer, next_timer;
  logic [ID_W-1:0] own, next_own;
  logic [ID_W-1:0] tgt, next_tgt;
  logic xfer_in, next_xfer_in;
  logic [BYTE_W-1:0] out_byte, next_out_byte;
  logic next_rx_valid;
  rx_byte_t next_rx;
  logic next_arb_lost, next_sel_timeout, next_connected;

  wstate_t wstate, next_wstate;
  logic [TIMER_W-1:0] wtimer, next_wtimer;
  logic wide_in, next_wide_in;
  logic wfull, next_wfull;
  logic [WIDE_W-1:0] whold, next_whold;
  logic next_wide_rx_valid, next_wide_tx_ready;
  wide_word_t next_wide_rx;

  bus_pins_t drv, drv_oe;
  logic conn;

  // Every bus line arrives from outside this clock and is filtered before use.
  pin_sync #(.W($bits(bus_pins_t))) u_sync (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_bus),
    .o_sync(b_vec)
  );
  assign b = b_vec;

  // Outbound bytes queue here so a stalled target pushes back on the source.
  byte_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_wr_valid(i_tx_valid),
    .i_wr_data(i_tx_data),
    .o_wr_ready(fifo_wr_ready),
    .o_rd_valid(fifo_rd_valid),
    .o_rd_data(fifo_rd_data),
    .i_rd_ready(fifo_rd_ready)
  );

  // Ready is the FIFO's own registered ready; a delayed copy would accept a byte the full FIFO drops.
  assign o_tx_ready = fifo_wr_ready;

  assign conn = (state == ST_CONN) || (state == ST_SETUP) || (state == ST_ACK);

  // Main sequencer: arbitration, selection, reselection and narrow handshakes.
  always_comb begin
    next_state = state;
    next_timer = (timer != TIMER_ZERO) ? timer - TIMER_ONE : timer;
    next_own = own;
    next_tgt = tgt;
    next_xfer_in = xfer_in;
    next_out_byte = out_byte;
    next_rx = o_rx;
    next_rx_valid = o_rx_valid && !i_rx_ready;
    next_arb_lost = 1'b0;
    next_sel_timeout = 1'b0;
    fifo_rd_ready = 1'b0;
    case (state)
      ST_IDLE: begin
        // Reselection: select with direction true, busy free, and our ID on the lines.
        if (b.sel && b.io && !b.bsy && ((b.db & id_bit(i_own_id)) != '0)) begin
          next_own = i_own_id;
          next_state = ST_RESEL;
        end else if (i_start && !b.bsy && !b.sel) begin
          next_own = i_own_id;
          next_tgt = i_target_id;
          next_timer = ARB_CYC;
          next_state = ST_ARB;
        end
      end
      ST_ARB: begin
        if (timer == TIMER_ZERO) begin
          // A higher ID on the lines or a select already up means we lost.
          if (outranked(b.db, own) || b.sel) begin
            next_arb_lost = 1'b1;
            next_state = ST_IDLE;
          end else begin
            next_timer = SETTLE_CYC;
            next_state = ST_SEL;
          end
        end
      end
      ST_SEL: begin
        if (timer == TIMER_ZERO) begin
          next_timer = SETTLE_CYC;
          next_state = ST_SEL_REL;
        end
      end
      ST_SEL_REL: begin
        // Our own busy release must clear the filter before the target's busy counts.
        if (timer == TIMER_ZERO) begin
          next_timer = TIMEOUT_CYC;
          next_state = ST_SEL_WAIT;
        end
      end
      ST_SEL_WAIT: begin
        if (b.bsy) begin
          next_state = ST_CONN;
        end else if (timer == TIMER_ZERO) begin
          next_sel_timeout = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_RESEL: begin
        if (!b.sel) begin
          next_state = ST_CONN;
        end
      end
      ST_CONN: begin
        if (!b.bsy) begin
          next_state = ST_IDLE;
        end else if (b.req) begin
          if (b.io) begin
            // Inbound byte is taken only when the previous one has been consumed.
            if (!o_rx_valid) begin
              next_rx.data = b.db;
              next_rx.cd = b.cd;
              next_rx.io = b.io;
              next_rx.msg = b.msg;
              next_rx.perr = (b.dbp != odd_par(b.db));
              next_rx_valid = 1'b1;
              next_xfer_in = 1'b1;
              next_state = ST_ACK;
            end
          end else if (fifo_rd_valid) begin
            fifo_rd_ready = 1'b1;
            next_out_byte = fifo_rd_data;
            next_xfer_in = 1'b0;
            next_timer = SETUP_CYC;
            next_state = ST_SETUP;
          end
        end
      end
      ST_SETUP: begin
        if (timer == TIMER_ZERO) begin
          next_state = ST_ACK;
        end
      end
      ST_ACK: begin
        if (!b.req) begin
          next_state = ST_CONN;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // A reset seen on the bus drops every role at once.
    if (b.rst) begin
      next_state = ST_IDLE;
    end
    next_connected = (next_state == ST_CONN) || (next_state == ST_SETUP) || (next_state == ST_ACK);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      timer <= TIMER_ZERO;
      own <= '0;
      tgt <= '0;
      xfer_in <= 1'b0;
      out_byte <= '0;
      o_rx <= '0;
      o_rx_valid <= 1'b0;
      o_arb_lost <= 1'b0;
      o_sel_timeout <= 1'b0;
      o_connected <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      own <= next_own;
      tgt <= next_tgt;
      xfer_in <= next_xfer_in;
      out_byte <= next_out_byte;
      o_rx <= next_rx;
      o_rx_valid <= next_rx_valid;
      o_arb_lost <= next_arb_lost;
      o_sel_timeout <= next_sel_timeout;
      o_connected <= next_connected;
    end
  end

  // Wide-lane handshake, live only in data phases while connected.
  always_comb begin
    next_wstate = wstate;
    next_wtimer = (wtimer != TIMER_ZERO) ? wtimer - TIMER_ONE : wtimer;
    next_wide_in = wide_in;
    next_whold = whold;
    next_wfull = wfull || (i_wide_tx_valid && o_wide_tx_ready);
    if (i_wide_tx_valid && o_wide_tx_ready) begin
      next_whold = i_wide_tx_data;
    end
    next_wide_rx = o_wide_rx;
    next_wide_rx_valid = o_wide_rx_valid && !i_wide_rx_ready;
    case (wstate)
      W_IDLE: begin
        if (conn && b.reqb && !b.cd && !b.msg) begin
          if (b.io) begin
            if (!o_wide_rx_valid) begin
              next_wide_rx.data = b.dbw;
              next_wide_rx.perr = (b.dbpw != lane_par(b.dbw));
              next_wide_rx_valid = 1'b1;
              next_wide_in = 1'b1;
              next_wstate = W_ACK;
            end
          end else if (wfull) begin
            next_wfull = 1'b0;
            next_wide_in = 1'b0;
            next_wtimer = SETUP_CYC;
            next_wstate = W_SETUP;
          end
        end
      end
      W_SETUP: begin
        if (wtimer == TIMER_ZERO) begin
          next_wstate = W_ACK;
        end
      end
      W_ACK: begin
        if (!b.reqb) begin
          next_wstate = W_IDLE;
        end
      end
      default: begin
        next_wstate = W_IDLE;
      end
    endcase
    if (!conn || b.rst) begin
      next_wstate = W_IDLE;
    end
    next_wide_tx_ready = !next_wfull;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wstate <= W_IDLE;
      wtimer <= TIMER_ZERO;
      wide_in <= 1'b0;
      wfull <= 1'b0;
      whold <= '0;
      o_wide_rx <= '0;
      o_wide_rx_valid <= 1'b0;
      o_wide_tx_ready <= 1'b0;
    end else begin
      wstate <= next_wstate;
      wtimer <= next_wtimer;
      wide_in <= next_wide_in;
      wfull <= next_wfull;
      whold <= next_whold;
      o_wide_rx <= next_wide_rx;
      o_wide_rx_valid <= next_wide_rx_valid;
      o_wide_tx_ready <= next_wide_tx_ready;
    end
  end

  // Pin drive. Wired-OR lines only ever assert; the rest are actively negated for speed.
  always_comb begin
    drv = '0;
    drv_oe = '0;
    // Target-sourced lines stay released; no enable is ever raised for them.
    drv_oe.bsy = (state == ST_ARB) || (state == ST_SEL) || (state == ST_RESEL);
    drv.bsy = 1'b1;
    drv_oe.sel = (state == ST_SEL) || (state == ST_SEL_REL) || (state == ST_SEL_WAIT);
    drv.sel = 1'b1;
    drv_oe.rst = i_bus_reset_req;
    drv.rst = 1'b1;
    drv_oe.atn = (state >= ST_SEL) && (state != ST_RESEL);
    drv.atn = i_atn_req;
    drv_oe.ack = conn;
    drv.ack = (state == ST_ACK);
    drv_oe.ackb = conn;
    drv.ackb = (wstate == W_ACK);
    case (state)
      ST_ARB: begin
        // Only our own ID line, parity left released.
        drv_oe.db = id_bit(own);
        drv.db = id_bit(own);
      end
      ST_SEL, ST_SEL_REL, ST_SEL_WAIT: begin
        drv_oe.db = '1;
        drv.db = id_bit(own) | id_bit(tgt);
        drv_oe.dbp = 1'b1;
        drv.dbp = odd_par(drv.db);
      end
      ST_SETUP, ST_ACK: begin
        drv_oe.db = {BYTE_W{!xfer_in}};
        drv.db = out_byte;
        drv_oe.dbp = !xfer_in;
        drv.dbp = odd_par(out_byte);
      end
      default: begin
        drv_oe.db = '0;
      end
    endcase
    if ((wstate == W_SETUP || wstate == W_ACK) && !wide_in) begin
      drv_oe.dbw = '1;
      drv.dbw = whold;
      drv_oe.dbpw = '1;
      drv.dbpw = lane_par(whold);
    end
    // A bus reset releases everything except our own reset drive.
    if (b.rst) begin
      drv_oe = '0;
      drv_oe.rst = i_bus_reset_req;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bus_out <= '0;
      o_bus_oe <= '0;
    end else begin
      o_bus_out <= drv;
      o_bus_oe <= drv_oe;
    end
  end

  // Checks on what this end drives onto the bus.
  property p_or_tied;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (o_bus_oe.bsy |-> o_bus_out.bsy) and (o_bus_oe.sel |-> o_bus_out.sel) and (o_bus_oe.rst |-> o_bus_out.rst);
  endproperty
  a_or_tied: assert property (p_or_tied) else $error("wired-OR line driven false");

  property p_target_lines;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      !(o_bus_oe.cd || o_bus_oe.io || o_bus_oe.msg || o_bus_oe.req || o_bus_oe.reqb);
  endproperty
  a_target_lines: assert property (p_target_lines) else $error("target-only line driven");

  property p_arb_parity;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      $past(state) == ST_ARB |-> (!o_bus_oe.dbp || o_bus_out.dbp);
  endproperty
  a_arb_parity: assert property (p_arb_parity) else $error("parity driven false in arbitration");

  property p_arb_id;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      $past(state) == ST_ARB && !b.rst |-> o_bus_oe.db == id_bit(own) && o_bus_out.db == id_bit(own);
  endproperty
  a_arb_id: assert property (p_arb_id) else $error("arbitration drives other than own ID");

  property p_narrow_parity;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      o_bus_oe.dbp |-> o_bus_out.dbp == ~^o_bus_out.db;
  endproperty
  a_narrow_parity: assert property (p_narrow_parity) else $error("narrow parity not odd");

  property p_wide_parity;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      o_bus_oe.dbpw != '0 |-> o_bus_out.dbpw == lane_par(o_bus_out.dbw);
  endproperty
  a_wide_parity: assert property (p_wide_parity) else $error("wide lane parity not odd");

  property p_data_dir;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      o_bus_oe.db != '0 && $past(conn) |-> !$past(xfer_in);
  endproperty
  a_data_dir: assert property (p_data_dir) else $error("data driven during inbound transfer");

  property p_ack_after_req;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      $rose(o_bus_out.ack) |-> $past(b.req) || $past(state) == ST_SETUP;
  endproperty
  a_ack_after_req: assert property (p_ack_after_req) else $error("acknowledge without request");

  property p_ackb_after_reqb;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      $rose(o_bus_out.ackb) |-> $past(b.reqb) || $past(wstate) == W_SETUP;
  endproperty
  a_ackb_after_reqb: assert property (p_ackb_after_reqb) else $error("wide acknowledge without request");

  property p_reset_drive;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      i_bus_reset_req |=> o_bus_oe.rst ##1 (!b.rst || (o_bus_oe.bsy == 1'b0 && o_bus_oe.db == '0));
  endproperty
  a_reset_drive: assert property (p_reset_drive) else $error("bus reset not driven or roles kept");

endmodule

//--- tb/bus_target.sv
// Behavioural target that answers selection and runs narrow handshakes.
module bus_target import bus_pkg::*; #(
  parameter logic [7:0] ID_BIT = 8'h01
) (
  input wire logic i_core_clk,
  input wire bus_pins_t i_line,
  output bus_pins_t o_drv
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_drv = '0;
  // Take the bus only after the initiator lets busy go, so two owners never overlap.
  always @(posedge i_core_clk) begin
    if (i_line.sel && (i_line.db & ID_BIT) != 8'h00 && !i_line.bsy) o_drv.bsy <= 1'b1;
  end
  // One byte per request; the data lines are let go afterwards and read false.
  task automatic xfer(input logic in, input logic [7:0] d, input logic bad, output logic [8:0] got);
    @(posedge i_core_clk);
    o_drv.io <= in;
    o_drv.db <= in ? d : 8'h00;
    o_drv.dbp <= in & (~^d ^ bad);
    repeat (3) @(posedge i_core_clk);
    o_drv.req <= 1'b1;
    while (i_line.ack !== 1'b1) @(posedge i_core_clk);
    got = {i_line.dbp, i_line.db};
    o_drv.req <= 1'b0;
    while (i_line.ack !== 1'b0) @(posedge i_core_clk);
    o_drv.db <= 8'h00;
    o_drv.dbp <= 1'b0;
  endtask
  // Release every line so the bus goes free.
  task automatic free();
    o_drv <= '0;
  endtask
endmodule

//--- tb/bus_initiator_bench.sv
// Self-checking bench for the bus initiator against a behavioural target.
module bus_initiator_bench import bus_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_start = 1'b0;
  logic i_atn_req = 1'b1;
  logic i_bus_reset_req = 1'b0;
  logic i_tx_valid = 1'b0;
  logic [7:0] i_tx_data = 8'h00;
  logic i_rx_ready = 1'b0;
  logic i_wide_rx_ready = 1'b1;
  logic o_tx_ready, o_rx_valid, o_connected;
  rx_byte_t o_rx;
  bus_pins_t o_bus_out, o_bus_oe, tdrv, line;
  logic [8:0] got;
  int n_errors = 0;
  int total_checks = 0;
  always #50 i_core_clk = ~i_core_clk;
  // Lines resolve as a wired OR; a released line reads false through the bias.
  assign line = (o_bus_out & o_bus_oe) | tdrv;
  bus_initiator dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_own_id(3'h2), .i_target_id(3'h0),
    .i_start(i_start), .i_atn_req(i_atn_req), .i_bus_reset_req(i_bus_reset_req), .i_tx_valid(i_tx_valid),
    .i_tx_data(i_tx_data), .o_tx_ready(o_tx_ready), .o_rx_valid(o_rx_valid), .o_rx(o_rx),
    .i_rx_ready(i_rx_ready), .i_wide_tx_valid(1'b0), .i_wide_tx_data(24'h000000), .o_wide_tx_ready(),
    .o_wide_rx_valid(), .o_wide_rx(), .i_wide_rx_ready(i_wide_rx_ready), .o_connected(o_connected), .o_arb_lost(),
    .o_sel_timeout(), .i_bus(line), .o_bus_out(o_bus_out), .o_bus_oe(o_bus_oe));
  bus_target #(.ID_BIT(8'h01)) tgt (.i_core_clk(i_core_clk), .i_line(line), .o_drv(tdrv));
  // Compare and count; an unknown never passes for a match.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  // Arbitrate and select, checking the drive pattern of each phase.
  task automatic t_select();
    int i;
    @(posedge i_core_clk);
    i_start <= 1'b1;
    @(posedge i_core_clk);
    i_start <= 1'b0;
    for (i = 0; i < 9 && o_bus_oe.bsy !== 1'b1; i++) tick(1);
    check({o_bus_out.bsy, o_bus_oe.db, o_bus_oe.dbp & ~o_bus_out.dbp}, 10'h208);
    for (i = 0; i < 60 && o_bus_oe.sel !== 1'b1; i++) tick(1);
    tick(1);
    check({o_bus_out.sel, line.db, line.dbp}, 10'h20b);
    for (i = 0; i < 40 && o_connected !== 1'b1; i++) tick(1);
    tick(1);
    check({o_connected, o_bus_oe.sel, o_bus_oe.cd, o_bus_oe.io, o_bus_oe.msg, o_bus_oe.req, line.atn}, 7'h41);
    $display("t_select done");
  endtask
  // Fill the buffer until it refuses, then let the target drain it in order.
  task automatic t_out();
    int n;
    n = 0;
    @(posedge i_core_clk);
    i_tx_valid <= 1'b1;
    repeat (24) begin
      @(posedge i_core_clk);
      if (o_tx_ready === 1'b1) n++;
      i_tx_data <= 8'(n);
    end
    i_tx_valid <= 1'b0;
    check(n, 16);
    for (int k = 0; k < 16; k++) begin
      tgt.xfer(1'b0, 8'h00, 1'b0, got);
      check(got, {~^k[7:0], k[7:0]});
    end
    tick(3);
    check(o_bus_oe.db, 8'h00);
    $display("t_out done");
  endtask
  // Two inbound bytes, the second with broken parity, the slot emptied between.
  task automatic t_in();
    tgt.xfer(1'b1, 8'h3c, 1'b0, got);
    check({o_rx_valid, o_rx}, {1'b1, 8'h3c, 4'b0100});
    check(o_bus_oe.db, 8'h00);
    @(posedge i_core_clk);
    i_rx_ready <= 1'b1;
    @(posedge i_core_clk);
    i_rx_ready <= 1'b0;
    tgt.xfer(1'b1, 8'hc1, 1'b1, got);
    check({o_rx_valid, o_rx}, {1'b1, 8'hc1, 4'b0101});
    $display("t_in done");
  endtask
  // Bus reset mid-connection: every drive but our own reset lets go.
  task automatic t_reset();
    @(posedge i_core_clk);
    i_bus_reset_req <= 1'b1;
    tgt.free();
    tick(8);
    check({o_bus_oe.rst, o_bus_out.rst, o_connected, o_bus_oe.ack, o_bus_oe.atn, o_bus_oe.bsy}, 6'h30);
    @(posedge i_core_clk);
    i_bus_reset_req <= 1'b0;
    $display("t_reset done");
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Main sequence; the bus filter needs a few edges after reset before a start.
  initial begin
    repeat (5) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    repeat (6) @(posedge i_core_clk);
    t_select();
    t_out();
    t_in();
    t_reset();
    complete_run();
  end
  // Watchdog: the tests need well under a thousand cycles.
  initial begin
    #2000000;
    n_errors++;
    complete_run();
  end
endmodule
